/* File: rtsc_reference_control.sv */
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ns
`include "rtsc_defs.svh"

// Operation
// - control bit 7 is read/write reference enable; 1 powers the reference
// - bit 6 is read-only ready flag; 0 while settling or switched off
// - on high-voltage variants the ready flag always reads 1
// - bit 5 enables the temperature indicator; cleared means no current
// - bit 4 picks temperature range: 1 four drops, 0 two drops
// - bits 3:2 set comparator/DAC buffer: off, 1x, 2x, 4x
// - bits 1:0 set converter buffer with the same coding
// - ready flag rises by itself once reference circuits have settled
// - the two gain fields drive two independent buffers
module rtsc_reference_control
  import rtsc_pkg::*;
#(
  parameter bit HIGH_VOLTAGE_VARIANT = 1'b0
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         clkEn,
  input  wire logic [3:0]   regAddr,
  input  wire logic [7:0]   regWrData,
  input  wire logic         regWrite,
  input  wire logic         regRead,
  output logic      [7:0]   regRdData,
  output rtsc_analog_t      analogCtrl,
  output logic              adcBufReady,
  output logic              cmpBufReady,
  output logic              irq
);

  typedef struct packed {
    rtsc_ctrl_t      ctrl;
    rtsc_ref_state_t refState;
    logic [15:0]     refCount;
    logic [3:0]      irqStatus;
    logic [3:0]      irqMask;
    logic            adcDonePrev;
    logic            cmpDonePrev;
    logic [7:0]      rdData;
    rtsc_analog_t    analog;
    logic            adcReady;
    logic            cmpReady;
    logic            irq;
  } rtsc_state_t;

  rtsc_state_t state;
  rtsc_state_t next_state;
  logic        adcDone;
  logic        cmpDone;
  logic        readyFlag;
  logic        adcRestart;
  logic        cmpRestart;
  logic        ctrlWrite;

  // decode the readable view of the control register
  function automatic logic [7:0] ctrl_word(input rtsc_ctrl_t c, input logic rdy);
    ctrl_word = {c.refEnable, rdy, c.tempSenseEnable, c.tempRangeSelect,
                 c.comparatorBufferGain, c.converterBufferGain};
  endfunction

  // ready flag, forced high on variants without a settling reference
  assign readyFlag = HIGH_VOLTAGE_VARIANT ? 1'b1 : (state.refState == RTSC_REF_READY);
  assign ctrlWrite = regWrite && (regAddr == `RTSC_IDX_CONTROL);

  // a gain change restarts that buffer's settle wait
  assign adcRestart = ctrlWrite && (regWrData[1:0] != state.ctrl.converterBufferGain);
  assign cmpRestart = ctrlWrite && (regWrData[3:2] != state.ctrl.comparatorBufferGain);

  // buffer settling timers, one per independent buffer
  rtsc_settle_timer #(
    .CYCLES (`RTSC_BUF_SETTLE_CYC)
  ) uAdcTimer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .restart  (adcRestart),
    .enable   (state.analog.adcBufOn && readyFlag),
    .done     (adcDone)
  );

  rtsc_settle_timer #(
    .CYCLES (`RTSC_BUF_SETTLE_CYC)
  ) uCmpTimer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .restart  (cmpRestart),
    .enable   (state.analog.cmpBufOn && readyFlag),
    .done     (cmpDone)
  );

  // next state: register writes, reference settling, events, read data
  always_comb begin
    logic [3:0] events;
    events     = 4'h0;
    next_state = state;

    // register writes; the ready bit position is never stored
    if (regWrite) begin
      if (regAddr == `RTSC_IDX_CONTROL) begin
        next_state.ctrl.refEnable            = regWrData[`RTSC_BIT_REF_EN];
        next_state.ctrl.tempSenseEnable      = regWrData[`RTSC_BIT_TEMP_EN];
        next_state.ctrl.tempRangeSelect      = regWrData[`RTSC_BIT_TEMP_RANGE];
        next_state.ctrl.comparatorBufferGain =
          rtsc_gain_t'(regWrData[`RTSC_BIT_CMP_GAIN_HI:`RTSC_BIT_CMP_GAIN_LO]);
        next_state.ctrl.converterBufferGain  =
          rtsc_gain_t'(regWrData[`RTSC_BIT_ADC_GAIN_HI:`RTSC_BIT_ADC_GAIN_LO]);
      end else if (regAddr == `RTSC_IDX_IRQ_MASK) begin
        next_state.irqMask = regWrData[3:0];
      end
    end

    // reference settling sequence
    case (state.refState)
      RTSC_REF_OFF: begin
        next_state.refCount = 16'h0000;
        if (state.ctrl.refEnable) begin
          next_state.refState = RTSC_REF_SETTLING;
        end
      end
      RTSC_REF_SETTLING: begin
        if (!state.ctrl.refEnable) begin
          next_state.refState = RTSC_REF_OFF;
        end else if (state.refCount == 16'(`RTSC_REF_SETTLE_CYC - 1)) begin
          next_state.refState = RTSC_REF_READY;
          events[`RTSC_IRQ_REF_READY] = 1'b1;
        end else begin
          next_state.refCount = state.refCount + 16'h0001;
        end
      end
      RTSC_REF_READY: begin
        if (!state.ctrl.refEnable) begin
          next_state.refState = RTSC_REF_OFF;
          events[`RTSC_IRQ_REF_LOST] = 1'b1;
        end
      end
      default: begin
        next_state.refState = RTSC_REF_OFF;
      end
    endcase

    // buffer settle completion events
    next_state.adcDonePrev = adcDone;
    next_state.cmpDonePrev = cmpDone;
    events[`RTSC_IRQ_ADC_READY] = adcDone && !state.adcDonePrev;
    events[`RTSC_IRQ_CMP_READY] = cmpDone && !state.cmpDonePrev;

    // sticky status: write one to clear, a new event wins over the clear
    if (regWrite && (regAddr == `RTSC_IDX_IRQ_STATUS)) begin
      next_state.irqStatus = state.irqStatus & ~regWrData[3:0];
    end
    next_state.irqStatus = next_state.irqStatus | events;

    // read data, valid the cycle after the strobe only
    next_state.rdData = 8'h00;
    if (regRead) begin
      if (regAddr == `RTSC_IDX_CONTROL) begin
        next_state.rdData = ctrl_word(state.ctrl, readyFlag);
      end else if (regAddr == `RTSC_IDX_IRQ_STATUS) begin
        next_state.rdData = {4'h0, state.irqStatus};
      end else if (regAddr == `RTSC_IDX_IRQ_MASK) begin
        next_state.rdData = {4'h0, state.irqMask};
      end else if (regAddr == `RTSC_IDX_SETTLE_STAT) begin
        next_state.rdData = {5'h00, cmpDone, adcDone, readyFlag};
      end else begin
        next_state.rdData = 8'h00;
      end
    end

    // registered analog controls from the stored fields
    next_state.analog.refPowerOn    = next_state.ctrl.refEnable;
    next_state.analog.tempPowerOn   = next_state.ctrl.tempSenseEnable;
    next_state.analog.tempHighRange = next_state.ctrl.tempRangeSelect;
    next_state.analog.cmpBufOn      = next_state.ctrl.comparatorBufferGain != RTSC_GAIN_OFF;
    next_state.analog.cmpGainSel    = next_state.ctrl.comparatorBufferGain;
    next_state.analog.adcBufOn      = next_state.ctrl.converterBufferGain != RTSC_GAIN_OFF;
    next_state.analog.adcGainSel    = next_state.ctrl.converterBufferGain;

    next_state.adcReady = adcDone;
    next_state.cmpReady = cmpDone;
    next_state.irq      = |(next_state.irqStatus & next_state.irqMask);
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else if (clkEn) begin
      state <= next_state;
    end
  end

  assign regRdData   = state.rdData;
  assign analogCtrl  = state.analog;
  assign adcBufReady = state.adcReady;
  assign cmpBufReady = state.cmpReady;
  assign irq         = state.irq;

endmodule

/* File: rtsc_defs.svh */
`ifndef RTSC_DEFS_SVH
`define RTSC_DEFS_SVH

// register indices (index, byte address is four times this)
`define RTSC_IDX_CONTROL      4'h0
`define RTSC_IDX_IRQ_STATUS   4'h1
`define RTSC_IDX_IRQ_MASK     4'h2
`define RTSC_IDX_SETTLE_STAT  4'h3

// control register bit positions
`define RTSC_BIT_REF_EN       7
`define RTSC_BIT_READY        6
`define RTSC_BIT_TEMP_EN      5
`define RTSC_BIT_TEMP_RANGE   4
`define RTSC_BIT_CMP_GAIN_HI  3
`define RTSC_BIT_CMP_GAIN_LO  2
`define RTSC_BIT_ADC_GAIN_HI  1
`define RTSC_BIT_ADC_GAIN_LO  0

// interrupt status / mask bit positions
`define RTSC_IRQ_REF_READY    0
`define RTSC_IRQ_ADC_READY    1
`define RTSC_IRQ_CMP_READY    2
`define RTSC_IRQ_REF_LOST     3

// reset values
`define RTSC_RST_CONTROL      8'h00
`define RTSC_RST_IRQ          4'h0

// timing
`define RTSC_CLK_MHZ          10
`define RTSC_BUF_SETTLE_US    30
`define RTSC_TEMP_ACQ_US      200
`define RTSC_REF_SETTLE_US    25
`define RTSC_BUF_SETTLE_CYC   (`RTSC_BUF_SETTLE_US * `RTSC_CLK_MHZ)
`define RTSC_REF_SETTLE_CYC   (`RTSC_REF_SETTLE_US * `RTSC_CLK_MHZ)

`endif

/* File: rtsc_pkg.sv */
package rtsc_pkg;

  // gain code of one reference buffer
  typedef enum logic [1:0] {
    RTSC_GAIN_OFF = 2'h0,
    RTSC_GAIN_X1  = 2'h1,
    RTSC_GAIN_X2  = 2'h2,
    RTSC_GAIN_X4  = 2'h3
  } rtsc_gain_t;

  // writable control fields
  typedef struct packed {
    logic       refEnable;
    logic       tempSenseEnable;
    logic       tempRangeSelect;
    rtsc_gain_t comparatorBufferGain;
    rtsc_gain_t converterBufferGain;
  } rtsc_ctrl_t;

  // analog enables towards the reference macro
  typedef struct packed {
    logic       refPowerOn;
    logic       tempPowerOn;
    logic       tempHighRange;
    logic       cmpBufOn;
    logic [1:0] cmpGainSel;
    logic       adcBufOn;
    logic [1:0] adcGainSel;
  } rtsc_analog_t;

  typedef enum {
    RTSC_REF_OFF,
    RTSC_REF_SETTLING,
    RTSC_REF_READY
  } rtsc_ref_state_t;

endpackage

/* File: rtsc_settle_timer.sv */
`timescale 1ns/1ns
`include "rtsc_defs.svh"

// counts a settling interval after its enable rises; done stays high while enabled until a restart
module rtsc_settle_timer
  import rtsc_pkg::*;
#(
  parameter int CYCLES = 300
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clkEn,
  input  wire logic restart,
  input  wire logic enable,
  output logic      done
);

  typedef struct packed {
    logic [15:0] count;
    logic        done;
  } rtsc_timer_st_t;

  rtsc_timer_st_t state;
  rtsc_timer_st_t next_state;

  // restart or disable drops done; a full count raises it
  always_comb begin
    next_state = state;
    if (!enable || restart) begin
      next_state.count = 16'h0000;
      next_state.done  = 1'b0;
    end else if (!state.done) begin
      if (state.count == 16'(CYCLES - 1)) begin
        next_state.done = 1'b1;
      end else begin
        next_state.count = state.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else if (clkEn) begin
      state <= next_state;
    end
  end

  assign done = state.done;

endmodule

/* File: rtsc_ref_ctrl_assertions.sv */
`timescale 1ns/1ns
module rtsc_ref_ctrl_assertions
  import rtsc_pkg::*;
#(
  parameter bit HIGH_VOLTAGE_VARIANT = 1'b0
) (
  input wire logic         core_clk,
  input wire logic         rst_n,
  input wire logic         clkEn,
  input wire logic [3:0]   regAddr,
  input wire logic [7:0]   regWrData,
  input wire logic         regWrite,
  input wire logic         regRead,
  input wire logic [7:0]   regRdData,
  input wire rtsc_analog_t analogCtrl,
  input wire logic         adcBufReady,
  input wire logic         cmpBufReady,
  input wire logic         irq
);
  logic [9:0] refCnt;
  logic [9:0] adcCnt;
  logic [9:0] cmpCnt;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // saturating run length of an enable that is held high
  function automatic logic [9:0] runLen(input logic [9:0] c, input logic on);
    return on ? c + {9'h000, c != 10'h3FF} : 10'h000;
  endfunction

  // count how long the reference and both buffer enables have stood
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refCnt <= 10'h000;
      adcCnt <= 10'h000;
      cmpCnt <= 10'h000;
    end else if (clkEn) begin
      refCnt <= runLen(refCnt, analogCtrl.refPowerOn);
      adcCnt <= runLen(adcCnt, analogCtrl.adcBufOn);
      cmpCnt <= runLen(cmpCnt, analogCtrl.cmpBufOn);
    end
  end

  sequence ctrlWr;
    regWrite && clkEn && regAddr == 4'h0;
  endsequence
  sequence ctrlRd;
    regRead && clkEn && regAddr == 4'h0;
  endsequence
  sequence refOff2;
    !analogCtrl.refPowerOn ##1 !analogCtrl.refPowerOn;
  endsequence

  chk_ref_enable: assert property (ctrlWr |=> analogCtrl.refPowerOn == $past(regWrData[7]))
    else $error("reference enable not applied");
  chk_temp_bits: assert property (ctrlWr |=> {analogCtrl.tempPowerOn, analogCtrl.tempHighRange} == $past(regWrData[5:4]))
    else $error("temperature sense bits not applied");
  chk_cmp_gain: assert property (ctrlWr |=> {analogCtrl.cmpBufOn, analogCtrl.cmpGainSel} == {$past(regWrData[3:2]) != 2'h0, $past(regWrData[3:2])})
    else $error("comparator buffer gain wrong");
  chk_adc_gain: assert property (ctrlWr |=> {analogCtrl.adcBufOn, analogCtrl.adcGainSel} == {$past(regWrData[1:0]) != 2'h0, $past(regWrData[1:0])})
    else $error("converter buffer gain wrong");
  chk_ready_off: assert property (refOff2 ##0 ctrlRd |=> regRdData[6] == HIGH_VOLTAGE_VARIANT)
    else $error("ready flag wrong with reference off");
  chk_ready_early: assert property (ctrlRd ##0 (refCnt != 10'h000 && refCnt < 10'd240 && !HIGH_VOLTAGE_VARIANT) |=> !regRdData[6])
    else $error("ready flag set while settling");
  chk_ready_late: assert property (ctrlRd ##0 refCnt >= 10'd260 |=> regRdData[6])
    else $error("ready flag not raised after settling");
  chk_adc_settle: assert property ($rose(adcBufReady) |-> adcCnt >= 10'd295)
    else $error("converter buffer ready too early");
  chk_cmp_settle: assert property ($rose(cmpBufReady) |-> cmpCnt >= 10'd295)
    else $error("comparator buffer ready too early");
endmodule

bind rtsc_reference_control rtsc_ref_ctrl_assertions #(.HIGH_VOLTAGE_VARIANT(HIGH_VOLTAGE_VARIANT))
  rtsc_ref_ctrl_assertions_inst (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .analogCtrl(analogCtrl), .adcBufReady(adcBufReady), .cmpBufReady(cmpBufReady), .irq(irq));

/* File: rtsc_reference_control_tb_top.sv */
`timescale 1ns/1ns
module rtsc_reference_control_tb_top;
  import rtsc_pkg::*;
  logic         core_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         clkEn = 1'b1;
  logic [3:0]   regAddr = 4'h0;
  logic [7:0]   regWrData = 8'h00;
  logic         regWrite = 1'b0;
  logic         regRead = 1'b0;
  logic [7:0]   regRdData;
  logic [7:0]   hvRdData;
  rtsc_analog_t analogCtrl;
  logic         adcBufReady;
  logic         cmpBufReady;
  logic         irq;
  logic [7:0]   rdVal;
  logic [7:0]   hvVal;
  int           n_fail = 0;
  int           samples_checked = 0;
  int           cycles = 0;

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  rtsc_reference_control rtsc_reference_control_inst (.core_clk, .rst_n, .clkEn, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .analogCtrl, .adcBufReady, .cmpBufReady, .irq);
  rtsc_reference_control #(.HIGH_VOLTAGE_VARIANT(1'b1)) rtsc_reference_control_inst_hv (.core_clk, .rst_n,
    .clkEn, .regAddr, .regWrData, .regWrite, .regRead, .regRdData(hvRdData), .analogCtrl(), .adcBufReady(),
    .cmpBufReady(), .irq());

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    rdVal = regRdData;
    hvVal = hvRdData;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic t_reset;
    rd(4'h0);
    chk("control", rdVal, 8'h00);
    chk("hv control", hvVal, 8'h40);
    chk("analog", analogCtrl[7:0], 8'h00);
    chk("ref power", {7'h00, analogCtrl.refPowerOn}, 8'h00);
    $display("test reset done");
  endtask

  // every gain code on both buffers, ready bit written high
  task automatic t_fields;
    logic [7:0] d;
    for (int g = 0; g < 4; g++) begin
      d = {2'b01, g[0], g[1], g[1:0], ~g[1:0]};
      wr(4'h0, d);
      rd(4'h0);
      chk("control", rdVal, d & 8'hBF);
      chk("hv control", hvVal, d | 8'h40);
      chk("analog", analogCtrl[7:0], {d[5:4], |d[3:2], d[3:2], |d[1:0], d[1:0]});
      chk("ref power", {7'h00, analogCtrl.refPowerOn}, 8'h00);
    end
    wr(4'hF, 8'hFF);
    rd(4'hF);
    chk("unmapped", rdVal, 8'h00);
    // temperature sense on, then the 200 us acquisition wait before any use
    wr(4'h0, 8'h20);
    idle(2000);
    rd(4'h0);
    chk("temp enable", rdVal, 8'h20);
    chk("temp power", {7'h00, analogCtrl.tempPowerOn}, 8'h01);
    wr(4'h0, 8'h00);
    $display("test fields done");
  endtask

  task automatic t_ready;
    wr(4'h2, 8'h0F);
    wr(4'h0, 8'h89);
    idle(100);
    rd(4'h0);
    chk("settling", rdVal, 8'h89);
    chk("irq quiet", {7'h00, irq}, 8'h00);
    idle(160);
    rd(4'h0);
    chk("ready", rdVal, 8'hC9);
    rd(4'h1);
    chk("status ref", rdVal, 8'h01);
    chk("irq ref", {7'h00, irq}, 8'h01);
    idle(310);
    rd(4'h1);
    chk("status bufs", rdVal, 8'h07);
    chk("bufs ready", {6'h00, cmpBufReady, adcBufReady}, 8'h03);
    wr(4'h0, 8'h8A);
    idle(3);
    chk("adc restart", {6'h00, cmpBufReady, adcBufReady}, 8'h02);
    wr(4'h1, 8'h0F);
    rd(4'h1);
    chk("status clear", rdVal, 8'h00);
    chk("irq clear", {7'h00, irq}, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h00);
    idle(3);
    rd(4'h1);
    chk("status lost", rdVal, 8'h08);
    chk("irq masked", {7'h00, irq}, 8'h00);
    rd(4'h0);
    chk("hv ready", hvVal, 8'h40);
    wr(4'h2, 8'h08);
    idle(2);
    chk("irq lost", {7'h00, irq}, 8'h01);
    wr(4'h1, 8'h08);
    rd(4'h0);
    chk("ref off", rdVal, 8'h00);
    chk("irq end", {7'h00, irq}, 8'h00);
    $display("test ready done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_fail++;
      tally_and_finish;
    end
  end

  initial begin
    idle(8);
    rst_n <= 1'b1;
    t_reset;
    t_fields;
    t_ready;
    tally_and_finish;
  end
endmodule
